// ===== common/swdt_pkg.sv
// Constants, register map and state carrier for the software watchdog.
// Assumes a single system clock and an AHB-Lite register slave.
package swdt_pkg;

	// Register byte addresses (word aligned)
	localparam logic [3:0] ADDR_CONTROL    = 4'h0;
	localparam logic [3:0] ADDR_SERVICE    = 4'h4;
	localparam logic [3:0] ADDR_IRQ_FLAG   = 4'h8;
	localparam logic [3:0] ADDR_RST_STATUS = 4'hc;

	// Control field positions
	localparam int CTL_LOCK_BIT = 15;
	localparam int CTL_FAST_BIT = 9;
	localparam int CTL_RWH_BIT  = 8;
	localparam int CTL_EN_BIT   = 7;
	localparam int CTL_RESP_LSB = 5;
	localparam int CTL_SEL_LSB  = 0;

	// Control writable mask and reset value
	localparam logic [15:0] CTL_MASK  = 16'h83ff;
	localparam logic [15:0] CTL_RESET = 16'h0000;

	// Service key values
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	// Counter step values and minimum select
	localparam logic [31:0] STEP_NORMAL = 32'h0000_0001;
	localparam logic [31:0] STEP_FAST   = 32'h0001_0001;
	localparam logic [4:0]  SEL_MIN     = 5'h08;

	// Time-out response encodings
	typedef enum logic [1:0] {
		RESP_IRQ    = 2'b00,
		RESP_IRQ_RST = 2'b01,
		RESP_RST    = 2'b10,
		RESP_WINDOW = 2'b11
	} resp_e;

	// Service sequence tracker
	typedef enum logic [0:0] {
		SVC_WAIT_FIRST  = 1'b0,
		SVC_WAIT_SECOND = 1'b1
	} svc_e;

	// Whole watchdog state
	typedef struct packed {
		logic [15:0] ctl;
		logic [31:0] count;
		svc_e        svc;
		logic        irq_flag;
		logic        first_done;
		logic        rst_req;
		logic        rst_cause;
		logic        dph_wr;
		logic [3:0]  dph_addr;
		logic [31:0] rdata;
	} wdt_state_s;

endpackage

// ===== design/software_watchdog_timer.sv
// Software watchdog timer with AHB-Lite register slave.
// Assumes the reset generator turns rst_req_o into resetn_i.
// Summary of operation
// - Lock bit freezes control until reset.
// - Test bit steps counter by 65537.
// - Halt stops counting unless run-while-halted.
// - Watchdog counts only while enabled.
// - Response 00: interrupt only, no reset.
// - Response 01: interrupt, then reset.
// - Response 10: reset on time-out.
// - Response 11: window, service last quarter.
// - Window: early service write resets.
// - Window: no service in quarter resets.
// - Any watchdog reset sets cause flag.
// - Reset request goes to reset generator.
// - Select n gives 2^n cycle time-out.
// - Select below 8 acts as 8.
// - Reset clears select, disables watchdog.
// - Key pair 55 then aa restarts count.
// - Other accesses between keys allowed.
// - Service cannot undo issued response.
// - Bad service value resets when enabled.
// - Flag bit 0 set on interrupt, W1C.
// - Unlocked control write restarts counter.
// - Service wins over simultaneous time-out.
`timescale 1ns/100ps
module software_watchdog_timer
	import swdt_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Core status, same clock domain
	input  wire logic        core_halted_i,
	// Watchdog outputs
	output logic             irq_o,
	output logic             rst_req_o,
	output logic             rst_cause_o
);

	wdt_state_s st_ff;
	wdt_state_s nxt_st;

	// Decoded control fields
	logic        lock;
	logic        fast;
	logic        rwh;
	logic        en;
	resp_e       resp;
	logic [4:0]  sel_raw;
	logic [4:0]  sel_eff;
	logic [31:0] limit;
	logic [31:0] win_start;
	logic        timeout;
	logic        in_window;
	logic        counting;
	logic        aph_valid;
	logic        wr_ctl;
	logic        wr_svc;
	logic        wr_irq;
	logic [7:0]  svc_val;
	logic        svc_done;
	logic        svc_bad;

	assign lock    = st_ff.ctl[CTL_LOCK_BIT];
	assign fast    = st_ff.ctl[CTL_FAST_BIT];
	assign rwh     = st_ff.ctl[CTL_RWH_BIT];
	assign en      = st_ff.ctl[CTL_EN_BIT];
	assign resp    = resp_e'(st_ff.ctl[CTL_RESP_LSB +: 2]);
	assign sel_raw = st_ff.ctl[CTL_SEL_LSB +: 5];

	assign sel_eff = (sel_raw < SEL_MIN) ? SEL_MIN : sel_raw;
	// limit is 2^n, window opens at three quarters
	assign limit     = STEP_NORMAL << sel_eff;
	assign win_start = limit - (limit >> 2);
	// Wide step can overshoot the limit, so compare with >=
	assign timeout   = en && (st_ff.count >= limit);
	assign in_window = st_ff.count >= win_start;
	assign counting  = en && (rwh || !core_halted_i);

	// Bus decode from the registered data phase
	assign aph_valid = hsel_i && hready_i && htrans_i[1];
	assign wr_ctl    = st_ff.dph_wr && (st_ff.dph_addr == ADDR_CONTROL);
	assign wr_svc    = st_ff.dph_wr && (st_ff.dph_addr == ADDR_SERVICE);
	assign wr_irq    = st_ff.dph_wr && (st_ff.dph_addr == ADDR_IRQ_FLAG);
	assign svc_val   = hwdata_i[7:0];
	// second key after first completes the pair
	// only service writes move the tracker
	assign svc_done  = wr_svc && (svc_val == KEY_SECOND) && (st_ff.svc == SVC_WAIT_SECOND);
	// any value other than the two keys
	assign svc_bad   = wr_svc && en && (svc_val != KEY_FIRST) && (svc_val != KEY_SECOND);

	// Next-state logic
	always_comb begin
		nxt_st = st_ff;
		// Data phase capture
		nxt_st.dph_wr   = aph_valid && hwrite_i;
		nxt_st.dph_addr = aph_valid ? haddr_i[3:0] : 4'h0;
		nxt_st.rdata    = 32'h0000_0000;
		if (aph_valid && !hwrite_i) begin
			if (haddr_i[3:0] == ADDR_CONTROL) begin
				nxt_st.rdata = {16'h0000, st_ff.ctl};
			end else if (haddr_i[3:0] == ADDR_IRQ_FLAG) begin
				nxt_st.rdata = {31'h0000_0000, st_ff.irq_flag};
			end else if (haddr_i[3:0] == ADDR_RST_STATUS) begin
				nxt_st.rdata = {31'h0000_0000, st_ff.rst_cause};
			end else begin
				nxt_st.rdata = 32'h0000_0000;
			end
		end

		// Counter advance
		if (counting) begin
			nxt_st.count = st_ff.count + (fast ? STEP_FAST : STEP_NORMAL);
		end

		if (wr_svc) begin
			if (st_ff.svc == SVC_WAIT_FIRST && svc_val == KEY_FIRST) begin
				nxt_st.svc = SVC_WAIT_SECOND;
			end else if (st_ff.svc == SVC_WAIT_SECOND && svc_val == KEY_FIRST) begin
				nxt_st.svc = SVC_WAIT_SECOND;
			end else begin
				nxt_st.svc = SVC_WAIT_FIRST;
			end
		end

		// Time-out response; completed service suppresses it
		if (timeout && !svc_done) begin
			nxt_st.count = 32'h0000_0000;
			case (resp)
				RESP_IRQ: begin
					nxt_st.irq_flag = 1'b1;
				end
				RESP_IRQ_RST: begin
					nxt_st.irq_flag = 1'b1;
					if (st_ff.first_done) begin
						nxt_st.rst_req = 1'b1;
					end
					nxt_st.first_done = 1'b1;
				end
				default: begin
					nxt_st.rst_req = 1'b1;
				end
			endcase
		end else if (svc_done && en) begin
			nxt_st.count      = 32'h0000_0000;
			nxt_st.first_done = 1'b0;
			if (resp == RESP_WINDOW && !in_window) begin
				nxt_st.rst_req = 1'b1;
			end
		end

		// any early service write in window mode
		if (wr_svc && en && resp == RESP_WINDOW && !in_window) begin
			nxt_st.rst_req = 1'b1;
		end
		if (svc_bad) begin
			nxt_st.rst_req = 1'b1;
		end

		// writes ignored while locked; write restarts counter
		if (wr_ctl && !lock) begin
			nxt_st.ctl        = hwdata_i[15:0] & CTL_MASK;
			nxt_st.count      = 32'h0000_0000;
			nxt_st.first_done = 1'b0;
		end

		// W1C flag, a new interrupt wins over the clear
		// service writes never clear the flag or the request
		if (wr_irq && hwdata_i[0] && !(timeout && !svc_done && resp != RESP_RST
				&& resp != RESP_WINDOW)) begin
			nxt_st.irq_flag = 1'b0;
		end

		// every watchdog reset sets the cause flag
		if (nxt_st.rst_req) begin
			nxt_st.rst_cause = 1'b1;
		end
	end

	// State register; select cleared and watchdog off at reset
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_ff <= '{ctl: CTL_RESET, count: 32'h0000_0000, svc: SVC_WAIT_FIRST,
				irq_flag: 1'b0, first_done: 1'b0, rst_req: 1'b0, rst_cause: 1'b0,
				dph_wr: 1'b0, dph_addr: 4'h0, rdata: 32'h0000_0000};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs; request held until reset generator acts
	assign hrdata_o    = st_ff.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
	assign irq_o       = st_ff.irq_flag;
	assign rst_req_o   = st_ff.rst_req;
	assign rst_cause_o = st_ff.rst_cause;

	property p_no_resp_disabled;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(!en && !wr_svc && !$rose(st_ff.irq_flag)) |=> !$rose(st_ff.rst_req) || $past(wr_ctl);
	endproperty
	a_no_resp_disabled: assert property (p_no_resp_disabled) else $error("response while disabled");

	property p_lock_holds;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		lock |=> $stable(st_ff.ctl);
	endproperty
	a_lock_holds: assert property (p_lock_holds) else $error("locked control changed");

	property p_irq_mode;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(timeout && resp == RESP_IRQ && !svc_done) |=> st_ff.irq_flag && !$rose(st_ff.rst_req)
			|| $past(svc_bad) || $past(wr_svc);
	endproperty
	a_irq_mode: assert property (p_irq_mode) else $error("irq mode misbehaved");

	property p_rst_mode;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(timeout && resp == RESP_RST && !svc_done) |=> st_ff.rst_req && st_ff.rst_cause;
	endproperty
	a_rst_mode: assert property (p_rst_mode) else $error("reset mode missed reset");

	property p_bad_value;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		svc_bad |=> st_ff.rst_req;
	endproperty
	a_bad_value: assert property (p_bad_value) else $error("bad key did not reset");

	property p_ctl_restart;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_ctl && !lock) |=> st_ff.count == 32'h0000_0000;
	endproperty
	a_ctl_restart: assert property (p_ctl_restart) else $error("count not restarted");

	property p_cause;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		st_ff.rst_req |-> st_ff.rst_cause;
	endproperty
	a_cause: assert property (p_cause) else $error("reset without cause flag");

	property p_svc_wins;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(timeout && svc_done && resp == RESP_IRQ && !wr_ctl) |=>
			st_ff.count == 32'h0000_0000 && $stable(st_ff.irq_flag);
	endproperty
	a_svc_wins: assert property (p_svc_wins) else $error("time-out beat service");

	property p_halt;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(core_halted_i && !rwh && !wr_ctl && !wr_svc && !timeout) |=> $stable(st_ff.count);
	endproperty
	a_halt: assert property (p_halt) else $error("counted while halted");

	// wide step on every counting cycle without time-out, control or service write
	property p_fast_step;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(counting && fast && !timeout && !wr_ctl && !wr_svc) |=>
			st_ff.count == $past(st_ff.count) + STEP_FAST;
	endproperty
	a_fast_step: assert property (p_fast_step) else $error("fast step wrong");

	// never shorter than the minimum period
	property p_min_period;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		timeout |-> st_ff.count >= (STEP_NORMAL << SEL_MIN);
	endproperty
	a_min_period: assert property (p_min_period) else $error("time-out below minimum");

	property p_first_timeout;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(timeout && resp == RESP_IRQ_RST && !svc_done && !st_ff.first_done
			&& !st_ff.rst_req && !wr_svc) |=> st_ff.irq_flag && !st_ff.rst_req;
	endproperty
	a_first_timeout: assert property (p_first_timeout) else $error("first time-out reset");

	property p_second_timeout;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(timeout && resp == RESP_IRQ_RST && !svc_done && st_ff.first_done) |=> st_ff.rst_req;
	endproperty
	a_second_timeout: assert property (p_second_timeout) else $error("second time-out missed");

	// pair inside the window is accepted
	property p_window_accept;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(svc_done && en && resp == RESP_WINDOW && in_window && !st_ff.rst_req) |=>
			!st_ff.rst_req && st_ff.count == 32'h0000_0000;
	endproperty
	a_window_accept: assert property (p_window_accept) else $error("window key refused");

	property p_window_early;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_svc && en && resp == RESP_WINDOW && !in_window) |=> st_ff.rst_req;
	endproperty
	a_window_early: assert property (p_window_early) else $error("early key no reset");

	property p_window_expire;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(timeout && resp == RESP_WINDOW && !svc_done) |=> st_ff.rst_req;
	endproperty
	a_window_expire: assert property (p_window_expire) else $error("window expiry no reset");

	property p_req_holds;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		st_ff.rst_req |=> st_ff.rst_req;
	endproperty
	a_req_holds: assert property (p_req_holds) else $error("reset request dropped");

	property p_svc_restart;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(svc_done && en) |=> st_ff.count == 32'h0000_0000;
	endproperty
	a_svc_restart: assert property (p_svc_restart) else $error("pair did not restart");

	property p_tracker_holds;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(st_ff.svc == SVC_WAIT_SECOND && !wr_svc) |=> st_ff.svc == SVC_WAIT_SECOND;
	endproperty
	a_tracker_holds: assert property (p_tracker_holds) else $error("tracker lost first key");

	property p_tracker_idle;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(svc_done || (wr_svc && svc_val != KEY_FIRST)) |=> st_ff.svc == SVC_WAIT_FIRST;
	endproperty
	a_tracker_idle: assert property (p_tracker_idle) else $error("tracker not idle");

	property p_svc_keeps_flag;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_svc && st_ff.irq_flag) |=> st_ff.irq_flag;
	endproperty
	a_svc_keeps_flag: assert property (p_svc_keeps_flag) else $error("service cleared flag");

	property p_flag_clear;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_irq && hwdata_i[0] && !timeout) |=> !st_ff.irq_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

	property p_flag_zero;
		@(posedge clk_sys_i) disable iff (!resetn_i)
		(wr_irq && !hwdata_i[0] && st_ff.irq_flag) |=> st_ff.irq_flag;
	endproperty
	a_flag_zero: assert property (p_flag_zero) else $error("zero write cleared flag");

endmodule

// ===== dv/test_software_watchdog_timer.sv
// Self-checking bench for the software watchdog timer.
// Assumes a zero-wait AHB-Lite slave; the bench drives every input but hready_i, which loops back hreadyout_o.
`timescale 1ns/100ps
module test_software_watchdog_timer import swdt_pkg::*;;
	logic        clk_sys_i   = 1'b0;
	logic        resetn_i    = 1'b0;
	logic        hsel_i      = 1'b0;
	logic [31:0] haddr_i     = 32'h0;
	logic [1:0]  htrans_i    = 2'b00;
	logic        hwrite_i    = 1'b0;
	logic [31:0] hwdata_i    = 32'h0;
	logic        halt        = 1'b0;
	logic        rd_dph      = 1'b0;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        irq_o;
	logic        rst_req_o;
	logic        rst_cause_o;
	logic        hresp_o;
	logic [31:0] exp_q[$];
	logic [4:0]  sel;
	int          num_errors  = 0;
	int          checks_done = 0;

	// 10 MHz system clock
	always #50 clk_sys_i = ~clk_sys_i;

	software_watchdog_timer i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
		.hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
		.hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .core_halted_i(halt), .irq_o(irq_o),
		.rst_req_o(rst_req_o), .rst_cause_o(rst_cause_o));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test();
		if (num_errors == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Read data compared at the edge closing its data phase
	always @(posedge clk_sys_i) begin
		if (rd_dph && hreadyout_o === 1'b1) begin
			chk("hrdata", exp_q.pop_front(), hrdata_o);
			chk("hresp", 32'h0, {31'h0, hresp_o});
		end
	end

	// Bounded wait for hready; a hang ends the run
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk_sys_i);
			n++;
		end while (hreadyout_o !== 1'b1 && n < 20);
		if (hreadyout_o !== 1'b1) begin
			num_errors++;
			finish_test();
		end
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		hsel_i   <= 1'b1;
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		haddr_i  <= {28'h0, a};
		wait_rdy();
		hsel_i   <= 1'b0;
		htrans_i <= 2'b00;
		hwdata_i <= d;
		rd_dph   <= !wr;
		wait_rdy();
		rd_dph   <= 1'b0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask

	// Sampled at the falling edge, away from register updates
	task automatic quiet(input logic which, input int cyc, input string nm);
		int n;
		for (n = 0; n < cyc; n++) begin
			@(negedge clk_sys_i);
			if ((which ? rst_req_o : irq_o) !== 1'b0) break;
		end
		chk(nm, 32'h0, {31'h0, (which ? rst_req_o : irq_o)});
		if (which) begin
			chk("cause", 32'h0, {31'h0, rst_cause_o});
		end
		@(posedge clk_sys_i);
	endtask

	task automatic wait_sig(input logic which, input int lim, input string nm);
		int n;
		for (n = 0; n < lim; n++) begin
			@(negedge clk_sys_i);
			if ((which ? rst_req_o : irq_o) === 1'b1) break;
		end
		chk(nm, 32'h1, {31'h0, (which ? rst_req_o : irq_o)});
		if (which) begin
			chk("cause", 32'h1, {31'h0, rst_cause_o});
		end
		@(posedge clk_sys_i);
	endtask

	task automatic do_reset();
		resetn_i <= 1'b0;
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		@(posedge clk_sys_i);
	endtask

	// Main sequence
	initial begin
		void'($urandom(32'h6493f5ec));
		do_reset();
		rd(4'h0, 32'h0); // control cleared
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		rd(4'hc, 32'h0);
		wr(4'h2, 32'hffff_ffff);
		rd(4'h2, 32'h0);
		rd(4'h0, 32'h0);
		sel = 5'($urandom_range(7, 0));
		wr(4'h0, {24'h0, 3'b100, sel});
		rd(4'h0, {24'h0, 3'b100, sel}); // field kept
		quiet(1'b0, 230, "irq early"); // minimum period
		wait_sig(1'b0, 60, "irq"); // interrupt raised
		quiet(1'b1, 20, "rst mode0"); // no reset
		wr(4'h4, 32'h55);
		wr(4'h4, 32'haa);
		rd(4'h8, 32'h1); // service keeps flag
		wr(4'h8, 32'h0);
		rd(4'h8, 32'h1); // zero ignored
		wr(4'h8, 32'h1);
		rd(4'h8, 32'h0); // one clears
		wr(4'h0, 32'h89);
		quiet(1'b0, 490, "irq sel9"); // period 512
		wait_sig(1'b0, 60, "irq sel9"); // period 512
		wr(4'h8, 32'h1); // handler clears flag
		wr(4'h0, 32'h294);
		quiet(1'b0, 12, "irq fast early"); // fast step
		wait_sig(1'b0, 40, "irq fast"); // fast step
		wr(4'h0, 32'h0);
		wr(4'h8, 32'h1);
		halt <= 1'b1;
		wr(4'h0, 32'h88);
		quiet(1'b0, 400, "irq halted"); // halt stops
		wr(4'h0, 32'h188);
		wait_sig(1'b0, 300, "irq run halted"); // keeps running
		halt <= 1'b0;
		wr(4'h0, 32'h08);
		wr(4'h8, 32'h1);
		quiet(1'b0, 400, "irq disabled"); // disabled
		wr(4'h0, 32'h88);
		for (int i = 0; i < 3; i++) begin
			quiet(1'b0, 180, "irq serviced"); // pair restarts
			wr(4'h4, 32'h55);
			rd(4'h0, 32'h88); // access between keys
			wr(4'h4, 32'haa);
		end
		quiet(1'b0, 180, "irq serviced"); // pair restarts
		wr(4'h0, 32'h88);
		quiet(1'b0, 180, "irq ctl write"); // control restarts
		wr(4'h4, 32'haa);
		wait_sig(1'b0, 100, "irq lone key"); // tracker idle
		wr(4'h4, {24'h0, 8'h56 + 8'($urandom_range(8'h50, 0))});
		wait_sig(1'b1, 10, "rst bad key"); // bad value
		rd(4'hc, 32'h1); // cause set
		do_reset();
		wr(4'h0, 32'hc8);
		quiet(1'b1, 230, "rst early"); // reset on time-out
		wait_sig(1'b1, 60, "rst mode2"); // reset on time-out
		rd(4'hc, 32'h1); // cause set
		do_reset();
		wr(4'h0, 32'ha8);
		quiet(1'b0, 230, "irq early"); // first time-out
		wait_sig(1'b0, 60, "irq mode1"); // first time-out
		quiet(1'b1, 200, "rst early"); // no reset yet
		wait_sig(1'b1, 80, "rst mode1"); // second time-out
		do_reset();
		wr(4'h0, 32'he8);
		quiet(1'b1, 50, "rst window");
		wr(4'h4, 32'h55);
		wait_sig(1'b1, 10, "rst early key"); // early service
		do_reset();
		wr(4'h0, 32'he8);
		quiet(1'b1, 200, "rst window"); // open window
		wr(4'h4, 32'h55);
		wr(4'h4, 32'haa);
		quiet(1'b1, 240, "rst serviced"); // late service
		wait_sig(1'b1, 40, "rst no key"); // missed window
		do_reset();
		wr(4'h0, 32'h8088);
		wr(4'h0, 32'h0);
		rd(4'h0, 32'h8088); // locked
		do_reset();
		rd(4'h0, 32'h0); // reset unlocks
		// Second key lands on the time-out edge
		wr(4'h0, 32'h88);
		wr(4'h4, 32'h55);
		repeat (253) @(posedge clk_sys_i);
		wr(4'h4, 32'haa); // key meets time-out
		quiet(1'b0, 200, "irq svc tie"); // service wins
		finish_test();
	end
endmodule
